// ===== bench/ick_checker.sv
// Checker: timing relations at the key block ports.
// Assumes one clock and the asynchronous active-high reset.
`timescale 1ns/10ps
module ick_checker (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rst,
  // I/O cycles
  input wire logic [9:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic       io_wr,
  input wire logic       io_rd,
  input wire logic       io_rdata_vld,
  input wire logic [1:0] ap_sel,
  // Status
  input wire logic       direct_config_method,
  input wire logic       second_unlock_key,
  input wire logic       chip_active,
  input wire logic [7:0] csn,
  input wire logic [5:0] ldev_active,
  input wire logic [9:0] rdp_addr,
  input wire logic       first_key_block
);
  logic [1:0] up_q;
  // Past values are stale for three edges after any reset
  wire        up = up_q == 2'h3;
  wire  [9:0] ap = ap_sel == 2'h1 ? 10'h20f : ap_sel == 2'h2 ? 10'h2af : 10'h279;
  wire        k1_end = io_wr && io_addr == ap && io_wdata == 8'h1a;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      up_q <= 2'h0;
    end else if (!up) begin
      up_q <= up_q + 2'h1;
    end
  end
  default clocking dc @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_sel_ctrl;
    second_unlock_key && io_wr && io_addr == ap && io_wdata == 8'h02;
  endsequence
  sequence s_wfk;
    io_wr && io_addr == rdp_addr && io_wdata == 8'h02;
  endsequence
  AST_KEY1_END: assert property (up && $rose(direct_config_method) |->
    $past(k1_end, 2) || $past(k1_end, 3)) else $error("direct mode without key end");
  AST_EXCL: assert property (!(direct_config_method && second_unlock_key))
    else $error("both key modes at once");
  AST_CSN: assert property (up && $changed(csn) |-> $past(io_wr))
    else $error("csn changed without a write");
  AST_LDEV: assert property (up && $changed(ldev_active) |-> $past(io_wr))
    else $error("activation changed without a write");
  AST_CHIP: assert property (up && $rose(chip_active) |->
    $past(io_wr) && $past(io_wdata) == 8'h79) else $error("chip on without 79");
  AST_RDP: assert property (up && $changed(rdp_addr) |-> rdp_addr[1:0] == 2'h3 &&
    rdp_addr[9:2] == $past(io_wdata) && $past(io_wr)) else $error("bad read port");
  AST_RD_ANS: assert property (second_unlock_key && io_rd && io_addr == rdp_addr
    |=> io_rdata_vld) else $error("read port gave no answer");
  AST_RD_CAUSE: assert property (up && io_rdata_vld |-> $past(io_rd))
    else $error("read answer without read");
  AST_FKB_HOLD: assert property (up && first_key_block |=> first_key_block)
    else $error("key block cleared");
  AST_EXIT: assert property (s_sel_ctrl ##2 s_wfk |-> ##[1:2] !second_unlock_key)
    else $error("second key mode not left");
endmodule
bind ick_config_key ick_checker chk (
  .mclk(mclk), .rst(rst), .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr),
  .io_rd(io_rd), .io_rdata_vld(io_rdata_vld), .ap_sel(ap_sel), .csn(csn),
  .direct_config_method(direct_config_method), .second_unlock_key(second_unlock_key),
  .chip_active(chip_active), .ldev_active(ldev_active), .rdp_addr(rdp_addr),
  .first_key_block(first_key_block)
);

// ===== bench/ick_host.sv
// Host model: ISA I/O write and read cycles.
// Assumes the bench clock; drives on its falling edge.
`timescale 1ns/10ps
module ick_host (
  // Clock
  input wire logic  mclk,
  // ISA I/O
  output logic [9:0] io_addr,
  output logic [7:0] io_wdata,
  output logic       io_wr,
  output logic       io_rd
);
  initial begin
    io_addr  = 10'h000;
    io_wdata = 8'h00;
    io_wr    = 1'b0;
    io_rd    = 1'b0;
  end
  task automatic cyc(input logic [9:0] a, input logic [7:0] d, input logic w);
    @(negedge mclk);
    io_addr  <= a;
    io_wdata <= d;
    io_wr    <= w;
    io_rd    <= !w;
    @(negedge mclk);
    // Released address and data lines show the inverse, never the old value
    io_addr  <= ~a;
    io_wdata <= ~d;
    io_wr    <= 1'b0;
    io_rd    <= 1'b0;
  endtask
endmodule

// ===== bench/isa_config_key_unlock_bench.sv
// Bench: keys, direct programming, second key, configuration image load.
// Assumes the host model drives I/O cycles and the checker is bound.
`timescale 1ns/10ps
module isa_config_key_unlock_bench;
  localparam logic [255:0] K1 = {128'h96359acde6f379bc5eaf572b158ac5e2,
                                 128'hf1f87c3e9f4f2713098442a1d068341a};
  localparam logic [255:0] K2 = {128'h95b1d86c369b4da6d369b45aadd6eb75,
                                 128'hbaddeef77b3d9ecf6733198c46a351a8};
  localparam logic [7:0] IO_CMD [3] = '{8'h47, 8'h48, 8'h42};
  localparam logic [7:0] ONE_CMD [4] = '{8'h22, 8'h27, 8'h2a, 8'h25};
  logic        mclk, rst, hw_load_start, hw_load_host, hw_byte_vld;
  logic [1:0]  ap_sel;
  logic [11:0] control_block_base;
  logic [7:0]  hw_byte, io_rdata, csn;
  wire  [9:0]  io_addr;
  wire  [7:0]  io_wdata;
  wire         io_wr, io_rd;
  logic        io_rdata_vld, direct_config_method, second_unlock_key, chip_active;
  logic        pnp_key_block, first_key_block, second_key_block, ee_present;
  logic [5:0]  ldev_active;
  logic [9:0]  rdp_addr;
  logic [15:0] ee_length;
  logic [23:0] interrupt_pins, ip;
  logic [11:0] dma_pin_pairs;
  logic [3:0]  irq_g_map;
  logic [81:0] ldev_res, er;
  logic [7:0]  img [1:23];
  logic [7:0]  exp_q [$];
  int          errors, checks_done, cyc_n;
  ick_host host (.mclk(mclk), .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr),
    .io_rd(io_rd));
  ick_config_key dut (.mclk(mclk), .rst(rst), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata), .io_rdata_vld(io_rdata_vld),
    .ap_sel(ap_sel), .control_block_base(control_block_base), .hw_load_start(hw_load_start),
    .hw_load_host(hw_load_host), .hw_byte_vld(hw_byte_vld), .hw_byte(hw_byte),
    .direct_config_method(direct_config_method), .second_unlock_key(second_unlock_key),
    .chip_active(chip_active), .csn(csn), .ldev_active(ldev_active), .rdp_addr(rdp_addr),
    .pnp_key_block(pnp_key_block), .first_key_block(first_key_block),
    .second_key_block(second_key_block), .ee_present(ee_present), .ee_length(ee_length),
    .interrupt_pins(interrupt_pins), .dma_pin_pairs(dma_pin_pairs), .irq_g_map(irq_g_map),
    .ldev_res(ldev_res));
  task automatic chk(input logic [81:0] got, input logic [81:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    host.cyc(a, d, 1'b1);
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.cyc(a, 8'h00, 1'b0);
    idle(2);
  endtask
  task automatic key(input logic [255:0] k, input logic [9:0] a, input int n);
    for (int i = 31; i > 31 - n; i--) begin
      wr(a, k[i*8 +: 8]);
    end
  endtask
  task automatic load(input logic hm);
    @(negedge mclk);
    hw_load_host  = hm;
    hw_load_start = 1'b1;
    @(negedge mclk);
    hw_load_start = 1'b0;
    for (int i = hm ? 5 : 1; i <= 23; i++) begin
      hw_byte_vld = 1'b1;
      hw_byte     = img[i];
      @(negedge mclk);
    end
    hw_byte_vld = 1'b0;
    hw_byte     = ~hw_byte;
    idle(3);
  endtask
  task automatic reset_dut();
    @(negedge mclk);
    rst = 1'b1;
    idle(12);
    rst = 1'b0;
    idle(2);
  endtask
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(negedge mclk) begin
    if (io_rdata_vld === 1'b1) begin
      chk(io_rdata, exp_q.size() > 0 ? exp_q.pop_front() : ~io_rdata);
    end
  end
  always @(posedge mclk) begin
    cyc_n++;
    // Whole run needs about 600 cycles
    if (cyc_n == 20000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    rst                = 1'b1;
    ap_sel             = 2'h0;
    control_block_base = 12'h120;
    hw_load_start      = 1'b0;
    hw_load_host       = 1'b0;
    hw_byte_vld        = 1'b0;
    hw_byte            = 8'h00;
    void'($urandom(18961));
    reset_dut();
    chk(interrupt_pins, 24'hfcb975);
    chk(dma_pin_pairs, 12'h310);
    chk(irq_g_map, 4'h0);
    chk(ee_length, 16'h00dd);
    $display("test defaults done");
    key(K1, 10'h279, 31);
    wr(10'h279, 8'h1b);
    idle(2);
    chk(direct_config_method, 1'b0);
    key(K1, 10'h279, 2);
    key(K1, 10'h279, 32);
    idle(2);
    chk(direct_config_method, 1'b1);
    $display("test first key done");
    wr(10'h279, 8'h06);
    wr(10'h279, 8'h01);
    idle(1);
    chk(csn, 8'h01);
    wr(10'h279, 8'h15);
    wr(10'h279, 8'h02);
    er = '0;
    for (int i = 0; i < 3; i++) begin
      er[i*16 +: 16] = 16'($urandom);
      wr(10'h279, IO_CMD[i]);
      wr(10'h279, er[i*16+8 +: 8]);
      wr(10'h279, er[i*16 +: 8]);
    end
    for (int i = 0; i < 4; i++) begin
      er[48+i*8 +: 8] = 8'($urandom);
      wr(10'h279, ONE_CMD[i]);
      wr(10'h279, er[48+i*8 +: 8]);
    end
    wr(10'h279, 8'h33);
    wr(10'h279, 8'h01);
    er[80] = 1'b1;
    idle(3);
    chk(ldev_res, er);
    chk(ldev_active, 6'h04);
    wr(10'h279, 8'h15);
    wr(10'h279, 8'h06);
    wr(10'h279, 8'h15);
    wr(10'h279, 8'h0b);
    idle(3);
    chk(ldev_res, er);
    wr(10'h279, 8'h33);
    wr(10'h279, 8'h00);
    idle(1);
    chk(ldev_active, 6'h00);
    wr(10'h279, 8'h79);
    idle(2);
    chk(chip_active, 1'b1);
    chk(direct_config_method, 1'b0);
    $display("test direct programming done");
    ap_sel = 2'h1;
    key(K2, 10'h20f, 32);
    wr(10'h20f, 8'h82);
    idle(2);
    chk(second_unlock_key, 1'b1);
    chk(rdp_addr, 10'h20b);
    wr(10'h20f, 8'h06);
    rd(10'h20b, 8'h01);
    wr(10'h20f, 8'h02);
    wr(10'h20b, 8'h02);
    idle(2);
    chk(second_unlock_key, 1'b0);
    $display("test second key done");
    wr(control_block_base[9:0] + 10'h005, 8'h56);
    wr(control_block_base[9:0] + 10'h005, 8'h55);
    idle(3);
    chk({pnp_key_block, first_key_block}, 2'h3);
    key(K1, 10'h20f, 32);
    idle(2);
    chk(direct_config_method, 1'b0);
    reset_dut();
    chk({pnp_key_block, first_key_block}, 2'h0);
    ap_sel = 2'h2;
    key(K1, 10'h2af, 32);
    idle(2);
    chk(direct_config_method, 1'b1);
    wr(10'h2af, 8'h79);
    $display("test key disables done");
    for (int i = 1; i <= 23; i++) begin
      img[i] = i >= 19 ? 8'($urandom) : 8'h00;
    end
    {img[1], img[2], img[3], img[4], img[7]} = 40'h55bb012308;
    {img[11], img[12], img[13], img[18]} = 32'h04081048;
    load(1'b0);
    chk({ee_present, ee_length}, 17'h10123);
    chk(interrupt_pins, {img[21], img[20], img[19]});
    chk({irq_g_map, dma_pin_pairs}, {img[23], img[22]});
    chk(second_key_block, 1'b1);
    key(K2, 10'h2af, 32);
    wr(10'h2af, 8'h82);
    idle(2);
    chk(second_unlock_key, 1'b0);
    ip = {img[21], img[20], img[19]};
    img[2] = 8'h00;
    img[19] = ~img[19];
    load(1'b0);
    chk({ee_present, interrupt_pins}, {1'b0, ip});
    img[20] = 8'($urandom);
    load(1'b1);
    chk(interrupt_pins, {img[21], img[20], img[19]});
    $display("test image load done");
    chk(exp_q.size(), 0);
    print_verdict();
  end
endmodule

// ===== design/ick_config_key.sv
// Configuration key detection, direct programming and second-key access.
// Assumes ISA I/O strobes already synchronised to mclk, one pulse per cycle.
`timescale 1ns/10ps
`include "ick_consts.svh"
// Function
// - Full first key on address port enters direct programming mode.
// - First key is 32 fixed bytes 96,35...1A matched in order.
// - Address port at 279h by default, two alternative locations selectable.
// - Command 06h plus data byte programs card select number.
// - Command 15h plus byte selects logical device 0 to 5.
// - Commands 47h,48h,42h take high then low byte for I/O bases.
// - Commands 22h,27h set interrupt select 0 and 1.
// - Commands 2Ah,25h set DMA select 0 and 1.
// - Command 33h with 01h activates device, with 00h deactivates.
// - Byte 79h activates chip and ends direct programming.
// - 55h at control base plus 5 blocks PnP key, 56h first key.
// - Key blocks persist until reset drive or power loss.
// - Second key is 32 fixed bytes 95,B1...A8 matched in order.
// - Byte 33 after second key gives read port bits 9:2, bits 1:0 11.
// - Second key enters configuration state directly, skipping isolation.
// - Read data port is read/write; no separate write data port.
// - 02h to address then 02h to read port returns to wait-for-key.
// - Config load takes 23 bytes from EEPROM, 19 from host.
// - EEPROM present only if first bytes are 55h then BBh.
// - Bytes 3 and 4 hold length, high first, low default DDh.
// - Bytes 19 to 21 map interrupt pins, lower nibble first.
// - Byte 22 maps DMA A/B, byte 23 DMA C and seventh interrupt.
// - Config byte 7 bits block PnP, first and second keys.
module ick_config_key import ick_pkg::*; #(
  parameter logic [255:0] KEY1 = {
    8'h96, 8'h35, 8'h9a, 8'hcd, 8'he6, 8'hf3, 8'h79, 8'hbc,
    8'h5e, 8'haf, 8'h57, 8'h2b, 8'h15, 8'h8a, 8'hc5, 8'he2,
    8'hf1, 8'hf8, 8'h7c, 8'h3e, 8'h9f, 8'h4f, 8'h27, 8'h13,
    8'h09, 8'h84, 8'h42, 8'ha1, 8'hd0, 8'h68, 8'h34, 8'h1a},
  parameter logic [255:0] KEY2 = {
    8'h95, 8'hb1, 8'hd8, 8'h6c, 8'h36, 8'h9b, 8'h4d, 8'ha6,
    8'hd3, 8'h69, 8'hb4, 8'h5a, 8'had, 8'hd6, 8'heb, 8'h75,
    8'hba, 8'hdd, 8'hee, 8'hf7, 8'h7b, 8'h3d, 8'h9e, 8'hcf,
    8'h67, 8'h33, 8'h19, 8'h8c, 8'h46, 8'ha3, 8'h51, 8'ha8}
) (
  // Clock and reset (reset is the ISA reset drive or power-on)
  input  wire logic        mclk,
  input  wire logic        rst,
  // ISA I/O access, one-cycle strobes
  input  wire logic [9:0]  io_addr,
  input  wire logic [7:0]  io_wdata,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  output logic      [7:0]  io_rdata,
  output logic             io_rdata_vld,
  // Address port selection
  input  wire logic [1:0]  ap_sel,
  // Control block base, as programmed for the control device
  input  wire logic [11:0] control_block_base,
  // Hardware configuration load stream
  input  wire logic        hw_load_start,
  input  wire logic        hw_load_host,
  input  wire logic        hw_byte_vld,
  input  wire logic [7:0]  hw_byte,
  // Status
  output logic             direct_config_method,
  output logic             second_unlock_key,
  output logic             chip_active,
  output logic [7:0]       csn,
  output logic [5:0]       ldev_active,
  output logic [9:0]       rdp_addr,
  output logic             pnp_key_block,
  output logic             first_key_block,
  output logic             second_key_block,
  output logic             ee_present,
  output logic [15:0]      ee_length,
  output logic [23:0]      interrupt_pins,
  output logic [11:0]      dma_pin_pairs,
  output logic [3:0]       irq_g_map,
  // Resource readback of the selected logical device
  output logic [81:0]      ldev_res
);
  // ****************************************************************
  // Decode
  // ****************************************************************
  localparam int RW = 82;
  ick_state_t   st_q, st_d;
  logic [7:0]   cmd_q;
  logic [1:0]   left_q;
  logic [7:0]   hi_q;
  logic [2:0]   ldn_q;
  logic [7:0]   pidx_q;
  logic [7:0]   hw_q [23];
  logic [4:0]   hw_idx_q;
  logic         hw_bad_q;
  logic         sw_pkb_q, sw_fkb_q;
  logic [9:0]   ap_addr;
  logic         ap_wr, rdp_wr, rdp_rd, ctl_wr;
  logic         key1_done, key2_done;
  logic         blk1, blk2;
  logic         cmd_wr, dat_wr;
  logic [RW-1:0] m_mask, m_data;
  logic [RW-1:0] m_rdata;
  logic         m_we;
  logic [4:0]   hw_slot;

  function automatic logic [1:0] data_count(input logic [7:0] c);
    unique case (c)
      `ICK_CMD_IO0, `ICK_CMD_IO1, `ICK_CMD_IO2: data_count = 2'h2;
      `ICK_CMD_CSN, `ICK_CMD_LDN, `ICK_CMD_IRQ0, `ICK_CMD_IRQ1,
      `ICK_CMD_DMA0, `ICK_CMD_DMA1, `ICK_CMD_ACT: data_count = 2'h1;
      default:                                  data_count = 2'h0;
    endcase
  endfunction

  assign ap_addr = (ap_sel == 2'h1) ? `ICK_AP_ALT2 :
                   (ap_sel == 2'h2) ? `ICK_AP_ALT3 : `ICK_AP_DEFAULT;
  assign ap_wr   = io_wr && (io_addr == ap_addr);
  assign rdp_wr  = io_wr && (io_addr == rdp_addr) && (st_q == ICK_ST_PNPC);
  assign rdp_rd  = io_rd && (io_addr == rdp_addr) && (st_q == ICK_ST_PNPC);
  assign ctl_wr  = io_wr && chip_active &&
                   (io_addr == control_block_base[9:0] + {6'h00, `ICK_CTRL_OFS});
  assign blk1    = first_key_block || (st_q != ICK_ST_WAIT);
  assign blk2    = second_key_block || (st_q != ICK_ST_WAIT);
  assign cmd_wr  = ap_wr && (st_q == ICK_ST_DCMD);
  assign dat_wr  = ap_wr && (st_q == ICK_ST_DDAT);

  ick_key_match #(.KEY(KEY1)) u_key1 (
    .mclk    (mclk),
    .rst     (rst),
    .wr_stb  (ap_wr),
    .wr_data (io_wdata),
    .blocked (blk1),
    .done    (key1_done)
  );

  ick_key_match #(.KEY(KEY2)) u_key2 (
    .mclk    (mclk),
    .rst     (rst),
    .wr_stb  (ap_wr),
    .wr_data (io_wdata),
    .blocked (blk2),
    .done    (key2_done)
  );

  // ****************************************************************
  // Mode sequencing
  // ****************************************************************
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ICK_ST_WAIT: begin
        if (key1_done) begin
          st_d = ICK_ST_DCMD;
        end else if (key2_done) begin
          st_d = ICK_ST_RDP;
        end
      end
      ICK_ST_DCMD: begin
        if (cmd_wr && io_wdata == `ICK_CMD_CHIP_ON) begin
          st_d = ICK_ST_WAIT;
        end else if (cmd_wr && data_count(io_wdata) != 2'h0) begin
          st_d = ICK_ST_DDAT;
        end
      end
      ICK_ST_DDAT: begin
        if (dat_wr && left_q == 2'h1) begin
          st_d = ICK_ST_DCMD;
        end
      end
      ICK_ST_RDP: begin
        if (ap_wr) begin
          st_d = ICK_ST_PNPC;
        end
      end
      ICK_ST_PNPC: begin
        if (rdp_wr && pidx_q == `ICK_CFG_CTRL_IDX && io_wdata == `ICK_WAIT_FOR_KEY) begin
          st_d = ICK_ST_WAIT;
        end
      end
    endcase
  end

  // ****************************************************************
  // Resource write assembly
  // ****************************************************************
  // Field layout: io0[15:0] io1[31:16] io2[47:32] irq0 irq1 dma0 dma1 act[80]
  always_comb begin
    m_mask = '0;
    m_data = '0;
    unique case (cmd_q)
      `ICK_CMD_IO0:  begin m_mask[15:0]  = 16'hffff; m_data[15:0]  = {hi_q, io_wdata}; end
      `ICK_CMD_IO1:  begin m_mask[31:16] = 16'hffff; m_data[31:16] = {hi_q, io_wdata}; end
      `ICK_CMD_IO2:  begin m_mask[47:32] = 16'hffff; m_data[47:32] = {hi_q, io_wdata}; end
      `ICK_CMD_IRQ0: begin m_mask[55:48] = 8'hff; m_data[55:48] = io_wdata; end
      `ICK_CMD_IRQ1: begin m_mask[63:56] = 8'hff; m_data[63:56] = io_wdata; end
      `ICK_CMD_DMA0: begin m_mask[71:64] = 8'hff; m_data[71:64] = io_wdata; end
      `ICK_CMD_DMA1: begin m_mask[79:72] = 8'hff; m_data[79:72] = io_wdata; end
      `ICK_CMD_ACT:  begin m_mask[80] = 1'b1; m_data[80] = io_wdata[0]; end
      default: ;
    endcase
  end
  // High byte arrives first, so only the last data byte writes
  assign m_we = dat_wr && left_q == 2'h1 && cmd_q != `ICK_CMD_CSN
                && cmd_q != `ICK_CMD_LDN;

  ick_ldev_mem #(.W(RW), .N(6)) u_mem (
    .mclk  (mclk),
    .rst   (rst),
    .we    (m_we),
    .waddr (ldn_q),
    .wmask (m_mask),
    .wdata (m_data),
    .raddr (ldn_q),
    .rdata (m_rdata)
  );

  // ****************************************************************
  // Command state
  // ****************************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q   <= ICK_ST_WAIT;
      cmd_q  <= 8'h00;
      left_q <= 2'h0;
      hi_q   <= 8'h00;
      ldn_q  <= 3'h0;
      pidx_q <= 8'h00;
    end else begin
      st_q <= st_d;
      if (cmd_wr) begin
        cmd_q  <= io_wdata;
        left_q <= data_count(io_wdata);
      end else if (dat_wr) begin
        left_q <= left_q - 2'h1;
        hi_q   <= io_wdata;
        if (cmd_q == `ICK_CMD_LDN && io_wdata < {5'h00, `ICK_NUM_LDEV}) begin
          ldn_q <= io_wdata[2:0];
        end
      end
      if (ap_wr && st_q == ICK_ST_PNPC) begin
        pidx_q <= io_wdata;
      end
    end
  end

  // ****************************************************************
  // Outputs and key blocks
  // ****************************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      csn          <= 8'h00;
      ldev_active  <= 6'h00;
      chip_active  <= 1'b0;
      rdp_addr     <= 10'h000;
      sw_pkb_q     <= 1'b0;
      sw_fkb_q     <= 1'b0;
      io_rdata     <= 8'h00;
      io_rdata_vld <= 1'b0;
      direct_config_method <= 1'b0;
      second_unlock_key    <= 1'b0;
      ldev_res     <= '0;
    end else begin
      direct_config_method <= st_d == ICK_ST_DCMD || st_d == ICK_ST_DDAT;
      second_unlock_key    <= st_d == ICK_ST_RDP || st_d == ICK_ST_PNPC;
      ldev_res     <= m_rdata;
      if (dat_wr && cmd_q == `ICK_CMD_CSN) begin
        csn <= io_wdata;
      end
      if (dat_wr && cmd_q == `ICK_CMD_ACT) begin
        ldev_active[ldn_q] <= io_wdata[0];
      end
      if (cmd_wr && io_wdata == `ICK_CMD_CHIP_ON) begin
        chip_active <= 1'b1;
      end
      if (st_q == ICK_ST_RDP && ap_wr) begin
        rdp_addr <= {io_wdata, `ICK_RDP_LOW};
      end
      // Cleared only by reset, which is reset drive or power-on
      if (ctl_wr && io_wdata == `ICK_DIS_PNP) begin
        sw_pkb_q <= 1'b1;
      end
      if (ctl_wr && io_wdata == `ICK_DIS_KEY1) begin
        sw_fkb_q <= 1'b1;
      end
      io_rdata_vld <= rdp_rd;
      if (rdp_rd) begin
        io_rdata <= (pidx_q == `ICK_CMD_CSN) ? csn : 8'h00;
      end
    end
  end

  // ****************************************************************
  // Hardware configuration image
  // ****************************************************************
  // Host load skips the validation and length bytes
  assign hw_slot = hw_load_host ? hw_idx_q + `ICK_HW_HOST_SKIP : hw_idx_q;
  localparam logic [183:0] HW_DEF = `ICK_HW_DEFAULTS;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `ICK_HW_LEN_EE; i++) begin
        hw_q[i] <= HW_DEF[i*8 +: 8];
      end
      hw_idx_q <= 5'h00;
      hw_bad_q <= 1'b0;
      ee_present <= 1'b0;
    end else begin
      if (hw_load_start) begin
        hw_idx_q <= 5'h00;
        hw_bad_q <= 1'b0;
        ee_present <= 1'b0;
      end else if (hw_byte_vld && !hw_bad_q && hw_slot < `ICK_HW_LEN_EE) begin
        hw_idx_q <= hw_idx_q + 5'h01;
        if ((hw_slot == 5'h00 && hw_byte != `ICK_EE_SIG0) ||
            (hw_slot == 5'h01 && hw_byte != `ICK_EE_SIG1)) begin
          hw_bad_q <= 1'b1;
        end else begin
          hw_q[hw_slot] <= hw_byte;
        end
        if (hw_slot == 5'h01 && hw_byte == `ICK_EE_SIG1 && !hw_load_host) begin
          ee_present <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pnp_key_block    <= 1'b0;
      first_key_block  <= 1'b0;
      second_key_block <= 1'b0;
      ee_length        <= 16'h0000;
      interrupt_pins   <= 24'h000000;
      dma_pin_pairs    <= 12'h000;
      irq_g_map        <= 4'h0;
    end else begin
      pnp_key_block    <= sw_pkb_q || hw_q[6][`ICK_B7_PKB];
      first_key_block  <= sw_fkb_q || hw_q[6][`ICK_B7_FKB];
      second_key_block <= hw_q[6][`ICK_B7_SKB];
      ee_length        <= {hw_q[2], hw_q[3]};
      interrupt_pins   <= {hw_q[20], hw_q[19], hw_q[18]};
      dma_pin_pairs    <= {hw_q[22][3:0], hw_q[21]};
      irq_g_map        <= hw_q[22][7:4];
    end
  end
endmodule

// ===== design/ick_consts.svh
// Constants for the configuration key and direct-programming logic.
// Included by every design module of the block.
`ifndef ICK_CONSTS_SVH
`define ICK_CONSTS_SVH
`define ICK_KEY_LEN        6'h20
`define ICK_AP_DEFAULT     10'h279
`define ICK_AP_ALT1        10'h279
`define ICK_AP_ALT2        10'h20f
`define ICK_AP_ALT3        10'h2af
`define ICK_CMD_CSN        8'h06
`define ICK_CMD_LDN        8'h15
`define ICK_CMD_IO0        8'h47
`define ICK_CMD_IO1        8'h48
`define ICK_CMD_IO2        8'h42
`define ICK_CMD_IRQ0       8'h22
`define ICK_CMD_IRQ1       8'h27
`define ICK_CMD_DMA0       8'h2a
`define ICK_CMD_DMA1       8'h25
`define ICK_CMD_ACT        8'h33
`define ICK_CMD_CHIP_ON    8'h79
`define ICK_CTRL_OFS       4'h5
`define ICK_DIS_PNP        8'h55
`define ICK_DIS_KEY1       8'h56
`define ICK_CFG_CTRL_IDX   8'h02
`define ICK_WAIT_FOR_KEY   8'h02
`define ICK_RDP_LOW        2'h3
`define ICK_EE_SIG0        8'h55
`define ICK_EE_SIG1        8'hbb
`define ICK_HW_LEN_EE      5'h17
`define ICK_HW_LEN_HOST    5'h13
`define ICK_HW_HOST_SKIP   5'h04
`define ICK_B7_PKB         5
`define ICK_B7_FKB         4
`define ICK_B7_SKB         3
`define ICK_NUM_LDEV       3'h6
`define ICK_HW_DEFAULTS    {8'h03, 8'h10, 8'hfc, 8'hb9, 8'h75, 8'h48, 8'h08, 8'h00, \
                            8'h00, 8'h80, 8'h10, 8'h08, 8'h04, 8'h20, 8'h05, 8'h00, \
                            8'h80, 8'h03, 8'h00, 8'hdd, 8'h00, 8'hbb, 8'h55}
`endif

// ===== design/ick_key_match.sv
// Matches one 32-byte unlock sequence on address port writes.
// Assumes one-cycle write strobes on the same clock; key byte order is fixed.
`timescale 1ns/10ps
`include "ick_consts.svh"
module ick_key_match import ick_pkg::*; #(
  parameter logic [255:0] KEY = 256'h0
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Address port write
  input  wire logic       wr_stb,
  input  wire logic [7:0] wr_data,
  input  wire logic       blocked,
  // Result
  output logic            done
);
  logic [5:0] idx_q;
  logic [5:0] idx_d;
  logic [7:0] expect_byte;
  logic [7:0] first_byte;
  logic       hit;
  logic       hit_first;

  assign expect_byte = KEY[255 - idx_q[4:0]*8 -: 8];
  assign first_byte  = KEY[255 -: 8];
  assign hit         = wr_data == expect_byte;
  assign hit_first   = wr_data == first_byte;
  // A breaking byte may itself start a fresh attempt
  assign idx_d = blocked ? 6'h00 :
                 !wr_stb ? idx_q :
                 hit ? ((idx_q == `ICK_KEY_LEN - 6'h01) ? 6'h00 : idx_q + 6'h01) :
                 (hit_first ? 6'h01 : 6'h00);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      idx_q <= 6'h00;
      done  <= 1'b0;
    end else begin
      idx_q <= idx_d;
      done  <= !blocked && wr_stb && hit && (idx_q == `ICK_KEY_LEN - 6'h01);
    end
  end
endmodule

// ===== design/ick_ldev_mem.sv
// Per-logical-device resource store, one word per device.
// Assumes a single writer; read data come out of a register.
`timescale 1ns/10ps
`include "ick_consts.svh"
module ick_ldev_mem #(
  parameter int W = 82,
  parameter int N = 6
) (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst,
  // Write
  input  wire logic                 we,
  input  wire logic [2:0]           waddr,
  input  wire logic [W-1:0]         wmask,
  input  wire logic [W-1:0]         wdata,
  // Read
  input  wire logic [2:0]           raddr,
  output logic      [W-1:0]         rdata
);
  logic [W-1:0] mem_q [N];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < N; i++) begin
        mem_q[i] <= '0;
      end
      rdata <= '0;
    end else begin
      if (we && (int'(waddr) < N)) begin
        mem_q[waddr] <= (mem_q[waddr] & ~wmask) | (wdata & wmask);
      end
      rdata <= (int'(raddr) < N) ? mem_q[raddr] : '0;
    end
  end
endmodule

// ===== design/ick_pkg.sv
// Types for the configuration key block.
// Constant values live in ick_consts.svh.
package ick_pkg;
  typedef enum logic [4:0] {
    ICK_ST_WAIT  = 5'h01,
    ICK_ST_DCMD  = 5'h02,
    ICK_ST_DDAT  = 5'h04,
    ICK_ST_RDP   = 5'h08,
    ICK_ST_PNPC  = 5'h10
  } ick_state_t;
endpackage
